// [hw/sstc_cfg.svh]
`ifndef SSTC_CFG_SVH
`define SSTC_CFG_SVH
// Register byte offsets
`define SSTC_OFS_CTRL      8'h00
`define SSTC_OFS_TCM       8'h04
`define SSTC_OFS_TFM       8'h08
`define SSTC_OFS_THR       8'h0C
`define SSTC_OFS_TSH       8'h10
`define SSTC_OFS_STAT      8'h14
// Control register fields
`define SSTC_CTRL_EN       0
`define SSTC_CTRL_RXEDGE   1
`define SSTC_CTRL_MDRIVE   2
`define SSTC_CTRL_EXT      7:4
`define SSTC_CTRL_DIV      27:16
// Transmit clock mode fields
`define SSTC_TCM_CKS       1:0
`define SSTC_TCM_CKO       4:2
`define SSTC_TCM_CKI       5
`define SSTC_TCM_CKG       7:6
`define SSTC_TCM_START     11:8
`define SSTC_TCM_DLY       23:16
`define SSTC_TCM_PERIOD    31:24
// Transmit frame mode fields
`define SSTC_TFM_LEN       4:0
`define SSTC_TFM_IDLE      5
`define SSTC_TFM_MSB_FIRST_FLAG      7
`define SSTC_TFM_NB        11:8
`define SSTC_TFM_FRAME_SYNC_LENGTH     19:16
`define SSTC_TFM_FRAME_SYNC_OUTPUT_SEL      22:20
`define SSTC_TFM_SYNC_DATA_ENABLE     23
`define SSTC_TFM_SYNC_EDGE_SELECT    24
// Status bits
`define SSTC_ST_EMPTY      0
`define SSTC_ST_TX_SYNC_STATUS_FLAG      1
`define SSTC_ST_RX_SYNC_STATUS_FLAG      2
`define SSTC_ST_BUSY       3
`define SSTC_ST_DMA        5:4
// Reset values
`define SSTC_RST_WORD      32'h0000_0000
`define SSTC_RST_TSH       16'h0000
// Field thresholds
`define SSTC_BYTE_MAX      5'h07
`define SSTC_HALF_MAX      5'h0F
`endif

// [hw/sstc_pkg.sv]
`default_nettype none
package sstc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_DATA} sstc_state_e;
  typedef enum logic [1:0] {DMA_BYTE, DMA_HALF, DMA_WORD} sstc_dma_e;
endpackage
`default_nettype wire

// [hw/sstc_tx.sv]
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sstc_cfg.svh"
module sstc_tx
#(
  parameter int WORD_W = 32
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Receiver side signals
  input  wire logic        rx_clock_signal,
  input  wire logic        rx_start,
  input  wire logic        rx_frame_sync,
  // Serial pins
  input  wire logic        tx_clock_pin_in,
  output logic             tx_clock_pin_out,
  output logic             tx_clock_pin_oe,
  input  wire logic        tx_frame_sync_pin_in,
  output logic             tx_frame_sync_pin_out,
  output logic             tx_frame_sync_pin_oe,
  output logic             tx_data_pin_out,
  output logic             tx_data_pin_oe,
  // DMA request side
  output logic             dma_tx_ready,
  output logic [1:0]       dma_size
);
  // Only a 32-bit word path is built
  if (WORD_W != 32)
  begin
    $error("WORD_W must be 32");
  end

  // ==========================================================
  // Register bus
  logic [31:0] ctrl, tcm, tfm, thr;
  logic [15:0] tsh;
  logic        thr_full, tx_sync_status_flag, rx_sync_status_flag;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_got, w_got;
  logic [31:0] next_ctrl, next_tcm, next_tfm, next_thr;
  logic [15:0] next_tsh;
  logic        next_thr_full, next_tx_sync_status_flag, next_rx_sync_status_flag;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic        next_aw_got, next_w_got, next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic        consume, tx_sync_status_flag_ev, rx_sync_status_flag_ev;
  logic [31:0] tsh_m;
  sstc_pkg::sstc_state_e state;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction

  always_comb
  begin
    tsh_m         = merge({16'h0000, tsh}, w_data, w_strb);
    next_ctrl     = ctrl;
    next_tcm      = tcm;
    next_tfm      = tfm;
    next_thr      = thr;
    next_tsh      = tsh;
    next_thr_full = thr_full & ~consume;
    next_tx_sync_status_flag    = tx_sync_status_flag;
    next_rx_sync_status_flag    = rx_sync_status_flag;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_aw_got   = aw_got;
    next_w_got    = w_got;
    next_bvalid   = s_axi_bvalid & ~s_axi_bready;
    next_bresp    = s_axi_bresp;
    next_rvalid   = s_axi_rvalid & ~s_axi_rready;
    next_rresp    = s_axi_rresp;
    next_rdata    = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_got && w_got && !s_axi_bvalid)
    begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = 2'b00;
      case (aw_addr)
        `SSTC_OFS_CTRL: next_ctrl = merge(ctrl, w_data, w_strb);
        `SSTC_OFS_TCM:  next_tcm  = merge(tcm, w_data, w_strb);
        `SSTC_OFS_TFM:  next_tfm  = merge(tfm, w_data, w_strb);
        `SSTC_OFS_TSH:
          next_tsh = tsh_m[15:0];
        `SSTC_OFS_THR:
        begin
          next_thr      = merge(thr, w_data, w_strb);
          next_thr_full = 1'b1;
        end
        `SSTC_OFS_STAT: next_bresp = 2'b00;
        default:        next_bresp = 2'b10;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      case (s_axi_araddr)
        `SSTC_OFS_CTRL: next_rdata = ctrl;
        `SSTC_OFS_TCM:  next_rdata = tcm;
        `SSTC_OFS_TFM:  next_rdata = tfm;
        `SSTC_OFS_THR:  next_rdata = `SSTC_RST_WORD;
        `SSTC_OFS_TSH:  next_rdata = {16'h0000, tsh};
        `SSTC_OFS_STAT:
        begin
          next_rdata = `SSTC_RST_WORD;
          next_rdata[`SSTC_ST_EMPTY] = ~thr_full;
          next_rdata[`SSTC_ST_TX_SYNC_STATUS_FLAG] = tx_sync_status_flag;
          next_rdata[`SSTC_ST_RX_SYNC_STATUS_FLAG] = rx_sync_status_flag;
          next_rdata[`SSTC_ST_BUSY]  = state != sstc_pkg::ST_IDLE;
          next_rdata[`SSTC_ST_DMA]   = dma_size;
          next_tx_sync_status_flag = 1'b0;
          next_rx_sync_status_flag = 1'b0;
        end
        default:
        begin
          next_rdata = `SSTC_RST_WORD;
          next_rresp = 2'b10;
        end
      endcase
    end
    // Flag set wins over read clear
    if (tx_sync_status_flag_ev)
      next_tx_sync_status_flag = 1'b1;
    if (rx_sync_status_flag_ev)
      next_rx_sync_status_flag = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= `SSTC_RST_WORD;
      tcm <= `SSTC_RST_WORD;
      tfm <= `SSTC_RST_WORD;
      thr <= `SSTC_RST_WORD;
      tsh <= `SSTC_RST_TSH;
      thr_full <= 1'b0;
      tx_sync_status_flag <= 1'b0;
      rx_sync_status_flag <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `SSTC_RST_WORD;
      w_strb <= 4'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= `SSTC_RST_WORD;
    end
    else
    begin
      ctrl <= next_ctrl;
      tcm <= next_tcm;
      tfm <= next_tfm;
      thr <= next_thr;
      tsh <= next_tsh;
      thr_full <= next_thr_full;
      tx_sync_status_flag <= next_tx_sync_status_flag;
      rx_sync_status_flag <= next_rx_sync_status_flag;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Clock selection, edges and period
  logic [11:0] div_cnt, next_div_cnt;
  logic        div_clk, next_div_clk, clk_q, rfs_q, tf_smp;
  logic        sel_clk, gate_ok, rise, fall, shift_tick, samp_tick;
  logic        tf_lvl, start_ev, per_ev;
  logic [8:0]  per_cnt, next_per_cnt;
  logic [7:0]  period;
  logic [11:0] div;

  assign div    = ctrl[`SSTC_CTRL_DIV];
  assign period = tcm[`SSTC_TCM_PERIOD];
  assign tf_lvl = tx_frame_sync_pin_oe ? tx_frame_sync_pin_out
                                       : tx_frame_sync_pin_in;

  always_comb
  begin
    next_div_cnt = div_cnt + 12'h001;
    next_div_clk = div_clk;
    if (div == 12'h000)
    begin
      next_div_cnt = 12'h000;
      next_div_clk = 1'b0;
    end
    else if (div_cnt >= div - 12'h001)
    begin
      next_div_cnt = 12'h000;
      next_div_clk = ~div_clk;
    end
    case (tcm[`SSTC_TCM_CKS])
      2'h0:    sel_clk = div_clk;
      2'h1:    sel_clk = rx_clock_signal;
      2'h2:    sel_clk = tx_clock_pin_in;
      default: sel_clk = 1'b0;
    endcase
    case (tcm[`SSTC_TCM_CKG])
      2'h0:    gate_ok = 1'b1;
      2'h1:    gate_ok = ~tf_lvl;
      2'h2:    gate_ok = tf_lvl;
      default: gate_ok = 1'b0;
    endcase
    rise = gate_ok & sel_clk & ~clk_q;
    fall = gate_ok & ~sel_clk & clk_q;
    shift_tick = tcm[`SSTC_TCM_CKI] ? rise : fall;
    samp_tick  = tcm[`SSTC_TCM_CKI] ? fall : rise;
    next_per_cnt = per_cnt;
    per_ev = 1'b0;
    if (period == 8'h00)
      next_per_cnt = 9'h000;
    else if (shift_tick)
    begin
      if (per_cnt >= {period, 1'b1})
      begin
        next_per_cnt = 9'h000;
        per_ev = 1'b1;
      end
      else
        next_per_cnt = per_cnt + 9'h001;
    end
    case (tcm[`SSTC_TCM_START])
      4'h0: start_ev = thr_full & (period == 8'h00 | per_ev);
      4'h1: start_ev = rx_start;
      4'h2: start_ev = samp_tick & ~tf_lvl;
      4'h3: start_ev = samp_tick & tf_lvl;
      4'h4: start_ev = samp_tick & tf_smp & ~tf_lvl;
      4'h5: start_ev = samp_tick & ~tf_smp & tf_lvl;
      4'h6,
      4'h7: start_ev = samp_tick & (tf_smp ^ tf_lvl);
      default: start_ev = 1'b0;
    endcase
    tx_sync_status_flag_ev = samp_tick & (tfm[`SSTC_TFM_SYNC_EDGE_SELECT] ? tf_smp & ~tf_lvl
                                                  : ~tf_smp & tf_lvl);
    rx_sync_status_flag_ev = ctrl[`SSTC_CTRL_RXEDGE] ? rfs_q & ~rx_frame_sync
                                       : ~rfs_q & rx_frame_sync;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt <= 12'h000;
      div_clk <= 1'b0;
      clk_q <= 1'b0;
      rfs_q <= 1'b0;
      tf_smp <= 1'b0;
      per_cnt <= 9'h000;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      div_clk <= next_div_clk;
      clk_q <= sel_clk;
      rfs_q <= rx_frame_sync;
      tf_smp <= samp_tick ? tf_lvl : tf_smp;
      per_cnt <= next_per_cnt;
    end
  end

  // ==========================================================
  // Transmit engine
  sstc_pkg::sstc_state_e next_state;
  logic [7:0]  dly, next_dly;
  logic [8:0]  fs_cnt, next_fs_cnt;
  logic [4:0]  idx, next_idx, len;
  logic [3:0]  words, next_words;
  logic [31:0] shreg, next_shreg;
  logic [15:0] sync_sh, next_sync;
  logic        pend, next_pend, tgl, next_tgl;
  logic        next_td, next_tf, next_tf_oe, next_tk, next_tk_oe;
  logic        busy;

  assign len = tfm[`SSTC_TFM_LEN];

  always_comb
  begin
    next_state  = state;
    next_dly    = dly;
    next_fs_cnt = fs_cnt;
    next_idx    = idx;
    next_words  = words;
    next_shreg  = shreg;
    next_sync   = sync_sh;
    next_tgl    = tgl;
    next_pend   = (pend | start_ev) & ctrl[`SSTC_CTRL_EN];
    consume     = 1'b0;
    if (shift_tick && ctrl[`SSTC_CTRL_EN])
    begin
      // sync pulse and sync data shift
      if (fs_cnt != 9'h000)
      begin
        next_fs_cnt = fs_cnt - 9'h001;
        next_sync   = sync_sh >> 1;
      end
      case (state)
        sstc_pkg::ST_IDLE:
          if (pend && thr_full)
          begin
            next_pend   = start_ev;
            next_fs_cnt = {1'b0, ctrl[`SSTC_CTRL_EXT],
                           tfm[`SSTC_TFM_FRAME_SYNC_LENGTH]} + 9'h001;
            next_sync   = tsh;
            next_tgl    = ~tgl;
            next_words  = tfm[`SSTC_TFM_NB];
            next_dly    = tcm[`SSTC_TCM_DLY];
            next_state  = sstc_pkg::ST_DELAY;
            if (tcm[`SSTC_TCM_DLY] == 8'h00)
            begin
              next_state = sstc_pkg::ST_DATA;
              next_shreg = thr;
              next_idx   = 5'h00;
              consume    = 1'b1;
            end
          end
        sstc_pkg::ST_DELAY:
          if (dly <= 8'h01)
          begin
            next_state = sstc_pkg::ST_DATA;
            next_shreg = thr;
            next_idx   = 5'h00;
            consume    = 1'b1;
          end
          else
            next_dly = dly - 8'h01;
        sstc_pkg::ST_DATA:
          // word of length plus one bits
          if (idx >= len)
          begin
            if (words != 4'h0 && thr_full)
            begin
              next_words = words - 4'h1;
              next_shreg = thr;
              next_idx   = 5'h00;
              consume    = 1'b1;
            end
            else
              next_state = sstc_pkg::ST_IDLE;
          end
          else
            next_idx = idx + 5'h01;
        default: next_state = sstc_pkg::ST_IDLE;
      endcase
    end
    busy = next_state != sstc_pkg::ST_IDLE;
    // bit order; sync data; idle level
    if (next_state == sstc_pkg::ST_DATA)
      next_td = tfm[`SSTC_TFM_MSB_FIRST_FLAG] ? next_shreg[len - next_idx]
                                    : next_shreg[next_idx];
    else if (next_fs_cnt != 9'h000 && tfm[`SSTC_TFM_SYNC_DATA_ENABLE])
      next_td = next_sync[0];
    else
      next_td = tfm[`SSTC_TFM_IDLE];
    next_tf_oe = 1'b1;
    case (tfm[`SSTC_TFM_FRAME_SYNC_OUTPUT_SEL])
      3'h1: next_tf = next_fs_cnt == 9'h000;
      3'h2: next_tf = next_fs_cnt != 9'h000;
      3'h3: next_tf = ~busy;
      3'h4: next_tf = busy;
      3'h5: next_tf = next_tgl;
      default:
      begin
        next_tf    = 1'b0;
        next_tf_oe = 1'b0;
      end
    endcase
    case (tcm[`SSTC_TCM_CKO])
      3'h1:
      begin
        next_tk    = sel_clk;
        next_tk_oe = 1'b1;
      end
      3'h2:
      begin
        next_tk    = sel_clk & busy;
        next_tk_oe = 1'b1;
      end
      default:
      begin
        next_tk    = 1'b0;
        next_tk_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= sstc_pkg::ST_IDLE;
      dly <= 8'h00;
      fs_cnt <= 9'h000;
      idx <= 5'h00;
      words <= 4'h0;
      shreg <= `SSTC_RST_WORD;
      sync_sh <= `SSTC_RST_TSH;
      pend <= 1'b0;
      tgl <= 1'b0;
      tx_data_pin_out <= 1'b0;
      tx_data_pin_oe <= 1'b0;
      tx_frame_sync_pin_out <= 1'b0;
      tx_frame_sync_pin_oe <= 1'b0;
      tx_clock_pin_out <= 1'b0;
      tx_clock_pin_oe <= 1'b0;
      dma_tx_ready <= 1'b0;
      dma_size <= sstc_pkg::DMA_BYTE;
    end
    else
    begin
      state <= next_state;
      dly <= next_dly;
      fs_cnt <= next_fs_cnt;
      idx <= next_idx;
      words <= next_words;
      shreg <= next_shreg;
      sync_sh <= next_sync;
      pend <= next_pend;
      tgl <= next_tgl;
      tx_data_pin_out <= next_td;
      tx_data_pin_oe <= ~ctrl[`SSTC_CTRL_MDRIVE] | next_td;
      tx_frame_sync_pin_out <= next_tf;
      tx_frame_sync_pin_oe <= next_tf_oe;
      tx_clock_pin_out <= next_tk;
      tx_clock_pin_oe <= next_tk_oe;
      dma_tx_ready <= ~next_thr_full & ctrl[`SSTC_CTRL_EN];
      if (len <= `SSTC_BYTE_MAX)
        dma_size <= sstc_pkg::DMA_BYTE;
      else if (len <= `SSTC_HALF_MAX)
        dma_size <= sstc_pkg::DMA_HALF;
      else
        dma_size <= sstc_pkg::DMA_WORD;
    end
  end

  // ==========================================================
  // Assertions
  property p_cks_res;
    @(posedge aclk) disable iff (!aresetn)
    tcm[`SSTC_TCM_CKS] == 2'h3 |-> !shift_tick && !samp_tick;
  endproperty
  a_cks_res: assert property (p_cks_res) else $error("reserved clk ticks");
  property p_cko_in;
    @(posedge aclk) disable iff (!aresetn)
    tcm[`SSTC_TCM_CKO] == 3'h0 |=> !tx_clock_pin_oe;
  endproperty
  a_cko_in: assert property (p_cko_in) else $error("tk driven");
  property p_shift_fall;
    @(posedge aclk) disable iff (!aresetn)
    shift_tick && !tcm[`SSTC_TCM_CKI] |-> clk_q && !sel_clk;
  endproperty
  a_shift_fall: assert property (p_shift_fall) else $error("not fall");
  property p_shift_rise;
    @(posedge aclk) disable iff (!aresetn)
    shift_tick && tcm[`SSTC_TCM_CKI] |-> !clk_q && sel_clk;
  endproperty
  a_shift_rise: assert property (p_shift_rise) else $error("not rise");
  property p_per;
    @(posedge aclk) disable iff (!aresetn)
    per_ev |-> period != 8'h00 && per_cnt == {period, 1'b1};
  endproperty
  a_per: assert property (p_per) else $error("bad period event");
  property p_frame_sync_output_sel_in;
    @(posedge aclk) disable iff (!aresetn)
    tfm[`SSTC_TFM_FRAME_SYNC_OUTPUT_SEL] == 3'h0 |=> !tx_frame_sync_pin_oe;
  endproperty
  a_frame_sync_output_sel_in: assert property (p_frame_sync_output_sel_in) else $error("tf driven");
  property p_idle_td;
    @(posedge aclk) disable iff (!aresetn)
    state == sstc_pkg::ST_IDLE && fs_cnt == 9'h000 && !shift_tick
      |=> tx_data_pin_out == $past(tfm[`SSTC_TFM_IDLE]);
  endproperty
  a_idle_td: assert property (p_idle_td) else $error("idle lvl");
  property p_mdrive;
    @(posedge aclk) disable iff (!aresetn)
    ctrl[`SSTC_CTRL_MDRIVE] ##1 !tx_data_pin_out |-> !tx_data_pin_oe;
  endproperty
  a_mdrive: assert property (p_mdrive) else $error("md drive");
  property p_dma;
    @(posedge aclk) disable iff (!aresetn)
    $stable(len) && len > `SSTC_HALF_MAX |=> dma_size == sstc_pkg::DMA_WORD;
  endproperty
  a_dma: assert property (p_dma) else $error("dma size");
  c_start: cover property (@(posedge aclk) disable iff (!aresetn)
    state == sstc_pkg::ST_IDLE ##1 state != sstc_pkg::ST_IDLE);
  c_reload: cover property (@(posedge aclk) disable iff (!aresetn)
    consume && state == sstc_pkg::ST_DATA);
  c_tx_sync_status_flag: cover property (@(posedge aclk) disable iff (!aresetn)
    tx_sync_status_flag_ev);
endmodule
`default_nettype wire

// [testbench/sstc_codec.sv]
`timescale 1ns/10ps
`default_nettype none
module sstc_codec
(
  // Sampling clock and serial pins
  input  wire logic        aclk,
  input  wire logic        sck,
  input  wire logic        fs,
  input  wire logic        sd,
  // Word format
  input  wire logic [4:0]  len,
  input  wire logic        msb_first_flag,
  // Received word
  output logic             got,
  output logic [31:0]      word
);
  logic        sck_q = 1'b0;
  logic [31:0] sr;
  int          n = -1;
  // ========================================
  // Capture on rising pin clock
  always @(posedge aclk)
  begin
    got <= 1'b0;
    sck_q <= sck;
    if (sck && !sck_q)
    begin
      if (fs)
        n = 0;
      if (n >= 0)
      begin
        sr = msb_first_flag ? {sr[30:0], sd} : {sd, sr[31:1]};
        n++;
        if (n == int'(len) + 1)
        begin
          got <= 1'b1;
          word <= msb_first_flag ? sr : sr >> (31 - len);
          n = -1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/ssc_transmit_clock_frame_config_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sstc_cfg.svh"
module ssc_transmit_clock_frame_config_tb;
  logic        aclk = 1'b0;
  logic        aresetn, rx_frame_sync, got;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, word, e;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dma_size;
  logic        tx_clock_pin_out, tx_clock_pin_oe, dma_tx_ready;
  logic        tx_frame_sync_pin_out, tx_frame_sync_pin_oe;
  logic        tx_data_pin_out, tx_data_pin_oe;
  logic [31:0] exp_q[$];
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  integer      seed = 32'ha12247ff;
  logic        m_flag = 1'b0;
  always #5 aclk = ~aclk;
  sstc_tx sstc_tx_i
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_clock_signal(1'b0),
    .rx_start(1'b0), .rx_frame_sync,
    .tx_clock_pin_in(tx_clock_pin_oe & tx_clock_pin_out),
    .tx_clock_pin_out, .tx_clock_pin_oe,
    .tx_frame_sync_pin_in(tx_frame_sync_pin_oe & tx_frame_sync_pin_out),
    .tx_frame_sync_pin_out, .tx_frame_sync_pin_oe,
    .tx_data_pin_out, .tx_data_pin_oe, .dma_tx_ready, .dma_size
  );
  sstc_codec sstc_codec_i
  (
    .aclk, .sck(tx_clock_pin_out), .fs(tx_frame_sync_pin_out),
    .sd(tx_data_pin_out), .len(5'h07),
    .msb_first_flag(m_flag), .got, .word
  );
  // ========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    check_count++;
    if (got_v !== exp_v)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ========================================
  // Monitor and timeout
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (got === 1'b1)
    begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : ~word;
      chk(word & 32'hff, e);
    end
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  // ========================================
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    aresetn = 1'b0;
    rx_frame_sync = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SSTC_OFS_TCM, d, r);
    chk(d, `SSTC_RST_WORD);
    rd(8'h40, d, r);
    chk(32'(r), 32'h2);
    $display("Register test done");
    wr(`SSTC_OFS_CTRL, 32'h0000_0004);
    for (int i = 1; i >= 0; i--)
    begin
      wr(`SSTC_OFS_TFM, 32'(i) << 5);
      rd(`SSTC_OFS_STAT, d, r);
      chk(32'(tx_data_pin_out), 32'(i));
      chk(32'(tx_data_pin_oe), 32'(i));
    end
    $display("Idle level test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(`SSTC_OFS_TFM, 32'(7 + i + (i >> 1) * 6));
      rd(`SSTC_OFS_STAT, d, r);
      chk(32'(d[5:4]), 32'(i == 0 ? 0 : i == 3 ? 2 : 1));
      chk(32'(dma_size), 32'(i == 0 ? 0 : i == 3 ? 2 : 1));
    end
    $display("Transfer size test done");
    for (int i = 0; i < 2; i++)
    begin
      wr(`SSTC_OFS_CTRL, 32'(i) << 1);
      rx_frame_sync <= ~i[0];
      wr(`SSTC_OFS_CTRL, 32'(i) << 1);
      rd(`SSTC_OFS_STAT, d, r);
      chk(32'(d[2]), 32'h1);
      rd(`SSTC_OFS_STAT, d, r);
      chk(32'(d[2]), 32'h0);
    end
    $display("Receive sync test done");
    wr(`SSTC_OFS_CTRL, 32'h0002_0001);
    wr(`SSTC_OFS_TCM, 32'h0000_0004);
    for (int m = 0; m < 2; m++)
    begin
      m_flag <= m[0];
      wr(`SSTC_OFS_TFM, 32'h0020_0007 | (32'(m) << 7));
      for (int k = 0; k < 3; k++)
      begin
        while (dma_tx_ready !== 1'b1) @(posedge aclk);
        d = $random(seed);
        exp_q.push_back(d & 32'hff);
        wr(`SSTC_OFS_THR, d);
      end
      while (exp_q.size() != 0) @(posedge aclk);
      chk(32'(tx_clock_pin_oe), 32'h1);
      chk(32'(tx_frame_sync_pin_oe), 32'h1);
    end
    rd(`SSTC_OFS_STAT, d, r);
    chk(32'(d[1:0]), 32'h3);
    $display("Serial word test done");
    results();
  end
endmodule
`default_nettype wire
